// file: logic/fsv_pkg.sv
// Purpose: Shared constants and carrier types for the fault supervisor
// Assumes: 40 MHz system clock
// Notes:   Status one and two bit layouts are per channel, two channels
package fsv_pkg;

    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned NUM_CH        = 2;
    // Restart timer base 3.6 ms, doubled per select step up to 28.8 ms
    localparam int unsigned RESTART_US    = 3600;
    localparam int unsigned RESTART_CYC   = (RESTART_US * (CLK_HZ / 1000)) / 1000;
    localparam int unsigned WD_BITS       = 25;
    localparam logic [4:0]  WD_TAP_RST    = 5'h18;
    localparam logic        WD_EN_RST     = 1'b1;
    localparam logic [1:0]  WD_LIMP_COUNT = 2'h3;
    localparam logic [1:0]  RT_SEL_RST    = 2'h0;

    // Status one field positions, per channel
    localparam int unsigned S1_SHORT  = 0;
    localparam int unsigned S1_HSLIM  = 1;
    localparam int unsigned S1_LSLIM  = 2;
    localparam int unsigned S1_COMPOV = 3;
    // Status two field positions, per channel
    localparam int unsigned S2_THERM  = 0;
    localparam int unsigned S2_BSTUV  = 1;
    localparam int unsigned S2_TOFF   = 2;
    // Status three field positions
    localparam int unsigned S3_PC     = 0;
    localparam int unsigned S3_SPE    = 1;
    localparam int unsigned S3_LIMP   = 2;
    localparam int unsigned S3_TW     = 3;
    localparam int unsigned S3_ANALOG_SUPPLY_UNDERVOLTAGE_FLAG  = 4;

    typedef struct packed {
        logic thermal;
        logic hs_limit;
        logic ls_limit;
        logic short_out;
        logic bst_uv;
        logic comp_ov;
        logic toff_min;
        logic vin_uv;
    } fsv_ch_cond_t;

    typedef struct packed {
        logic       thermal_latch_select;
        logic       highside_limit_latch_select;
        logic       lowside_limit_latch_select;
    } fsv_ch_cfg_t;

    typedef enum logic [1:0] {
        FSV_RD_NONE,
        FSV_RD_ONE,
        FSV_RD_TWO,
        FSV_RD_THREE
    } fsv_rd_sel_t;

endpackage

// file: logic/fsv_restart_timer.sv
// Purpose: Per-channel restart fault timer
// Assumes: start is a one-cycle pulse
// Notes:   Expiry is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module fsv_restart_timer (
    input  wire logic       clk_sys_i,
    input  wire logic       arst_n_i,
    input  wire logic       ce_i,
    input  wire logic       start_i,
    input  wire logic [1:0] sel_i,
    output logic            busy_o,
    output logic            done_o
);
    import fsv_pkg::*;

    logic [23:0] cnt_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q  <= 24'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (start_i) begin
                // 3.6, 7.2, 14.4 or 28.8 ms
                cnt_q  <= 24'(RESTART_CYC) << sel_i;
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (cnt_q <= 24'h1) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                cnt_q <= cnt_q - 24'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: logic/fsv_fault_supervisor.sv
// Purpose: Fault flags, latch/restart control, watchdog and fault pin
// Assumes: Analog condition inputs are asynchronous and synchronised here;
//          SPI framing lives outside and gives same-clock strobes
// Notes:   Status flags clear on the end of the read-response transfer
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Every fault or diagnostic except core and input undervoltage sets a sticky flag.
// - Status read clears flags whose condition has gone; persisting ones stay.
// - Clearing happens at end of read-response transfer, not command frame.
// - Latch bit high: thermal or current-limit fault holds the channel off.
// - Latched channel resumes only after flag cleared and enable written again.
// - Latch bit zero: fault runs automatic restart instead of holding off.
// - Non-latched thermal restarts with soft-start when sensor reports recovery.
// - Non-latched current limit starts fault timer; switching resumes on expiry.
// - Two-bit select gives restart timer from 3.6 ms to 28.8 ms.
// - Watchdog runs on system clock and is enabled after reset.
// - Watchdog is 25-bit counter, tap selectable, default tap bit 24.
// - Watchdog timeout sets the SPI error flag.
// - Current limits and thermal fault pull the active-low fault pin low.
// - Writing release frees the fault pin when no fault remains active.
// - Power cycle has flag, asserts fault pin, latches, no restart timer.
// - Bootstrap undervoltage sets its flag, turns high side off and forces low side on.
// - Input undervoltage has no flag; it only stops switching.
// - Limp-home entry sets a flag only; no pin, timer or latch.
// - Output short flag set when sense negative input falls below threshold.
// - Output short never stops switching.
// - High-side limit turns high side off, low side on, sets flag.
// - Thermal protection shuts channel down and sets status two flag.
// - Three consecutive watchdog timeouts enter limp-home.
module fsv_fault_supervisor (
    input  wire logic                   clk_sys_i,
    input  wire logic                   arst_n_i,
    input  wire logic                   ce_i,
    input  wire fsv_pkg::fsv_ch_cond_t  ch_cond_i [2],
    input  wire logic                   thermal_warning_i,
    input  wire logic                   analog_supply_uv_i,
    input  wire fsv_pkg::fsv_ch_cfg_t   ch_cfg_i [2],
    input  wire logic [1:0]             restart_timer_select_i,
    input  wire logic [1:0]             channel_enable_set_i,
    input  wire logic                   watchdog_enable_wr_i,
    input  wire logic                   watchdog_enable_val_i,
    input  wire logic                   watchdog_tap_wr_i,
    input  wire logic [4:0]             watchdog_tap_val_i,
    input  wire logic                   spi_frame_ok_i,
    input  wire logic                   fault_pin_release_i,
    input  wire logic                   rd_done_i,
    input  wire fsv_pkg::fsv_rd_sel_t   rd_sel_i,
    output logic [7:0]                  fault_status_one_o,
    output logic [5:0]                  fault_status_two_o,
    output logic [4:0]                  fault_status_three_o,
    output logic [1:0]                  channel_enable_bit_o,
    output logic [1:0]                  switching_en_o,
    output logic [1:0]                  soft_start_o,
    output logic [1:0]                  highside_on_en_o,
    output logic [1:0]                  lowside_force_on_o,
    output logic                        watchdog_enable_bit_o,
    output logic [4:0]                  watchdog_tap_select_o,
    output logic                        limp_home_o,
    output logic                        fault_output_pin_oe_n_o
);
    import fsv_pkg::*;

    // Two-stage synchronisers for the analog condition levels
    fsv_ch_cond_t cs1_q [2];
    fsv_ch_cond_t cs_q  [2];
    logic [1:0]   gs1_q, gs_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs1_q <= '{default: '0};
            cs_q  <= '{default: '0};
            gs1_q <= 2'h0;
            gs_q  <= 2'h0;
        end else if (ce_i) begin
            cs1_q <= ch_cond_i;
            cs_q  <= cs1_q;
            gs1_q <= {analog_supply_uv_i, thermal_warning_i};
            gs_q  <= gs1_q;
        end
    end

    // Sticky flag update: set wins over clear-on-read
    function automatic logic sticky(input logic flag, input logic cond,
                                    input logic clr);
        sticky = cond | (flag & ~clr);
    endfunction

    logic clr1, clr2, clr3;
    assign clr1 = rd_done_i && (rd_sel_i == FSV_RD_ONE);
    assign clr2 = rd_done_i && (rd_sel_i == FSV_RD_TWO);
    assign clr3 = rd_done_i && (rd_sel_i == FSV_RD_THREE);

    logic [1:0] limp_set;

    // Power-cycle flag starts set; reset stands for power-on
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fault_status_one_o   <= 8'h0;
            fault_status_two_o   <= 6'h0;
            fault_status_three_o <= 5'h1;
        end else if (ce_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                // Flag stays while condition persists, otherwise cleared by the matching status read
                fault_status_one_o[4*c+S1_SHORT] <= sticky(
                    fault_status_one_o[4*c+S1_SHORT], cs_q[c].short_out, clr1);
                fault_status_one_o[4*c+S1_HSLIM] <= sticky(
                    fault_status_one_o[4*c+S1_HSLIM], cs_q[c].hs_limit, clr1);
                fault_status_one_o[4*c+S1_LSLIM] <= sticky(
                    fault_status_one_o[4*c+S1_LSLIM], cs_q[c].ls_limit, clr1);
                fault_status_one_o[4*c+S1_COMPOV] <= sticky(
                    fault_status_one_o[4*c+S1_COMPOV], cs_q[c].comp_ov, clr1);
                fault_status_two_o[3*c+S2_THERM] <= sticky(
                    fault_status_two_o[3*c+S2_THERM], cs_q[c].thermal, clr2);
                fault_status_two_o[3*c+S2_BSTUV] <= sticky(
                    fault_status_two_o[3*c+S2_BSTUV], cs_q[c].bst_uv, clr2);
                fault_status_two_o[3*c+S2_TOFF] <= sticky(
                    fault_status_two_o[3*c+S2_TOFF], cs_q[c].toff_min, clr2);
            end
            // Power cycle has no live condition after start-up
            fault_status_three_o[S3_PC] <= sticky(
                fault_status_three_o[S3_PC], 1'b0, clr3);
            fault_status_three_o[S3_SPE] <= sticky(
                fault_status_three_o[S3_SPE], limp_set[0], clr3);
            fault_status_three_o[S3_LIMP] <= sticky(
                fault_status_three_o[S3_LIMP], limp_set[1], clr3);
            fault_status_three_o[S3_TW] <= sticky(
                fault_status_three_o[S3_TW], gs_q[0], clr3);
            fault_status_three_o[S3_ANALOG_SUPPLY_UNDERVOLTAGE_FLAG] <= sticky(
                fault_status_three_o[S3_ANALOG_SUPPLY_UNDERVOLTAGE_FLAG], gs_q[1], clr3);
        end
    end

    // Per-channel latch and restart control
    logic [1:0] latched_q, therm_wait_q, tmr_start, tmr_busy, tmr_done;
    logic [1:0] lat_evt, cl_evt, th_evt, flag_live, pc_latch;

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            th_evt[c] = cs_q[c].thermal;
            cl_evt[c] = cs_q[c].hs_limit | cs_q[c].ls_limit;
            lat_evt[c] = (th_evt[c] & ch_cfg_i[c].thermal_latch_select)
                | (cs_q[c].hs_limit & ch_cfg_i[c].highside_limit_latch_select)
                | (cs_q[c].ls_limit & ch_cfg_i[c].lowside_limit_latch_select);
            flag_live[c] = fault_status_one_o[4*c+S1_HSLIM]
                         | fault_status_one_o[4*c+S1_LSLIM]
                         | fault_status_two_o[3*c+S2_THERM];
            // Non-latched current limit arms timer whenever present and timer idle
            tmr_start[c] = ce_i & cl_evt[c] & ~lat_evt[c] & ~tmr_busy[c];
        end
        pc_latch = {2{fault_status_three_o[S3_PC]}};
    end

    for (genvar g = 0; g < 2; g++) begin : g_tmr
        fsv_restart_timer u_tmr (
            .clk_sys_i (clk_sys_i),
            .arst_n_i  (arst_n_i),
            .ce_i      (ce_i),
            .start_i   (tmr_start[g]),
            .sel_i     (restart_timer_select_i),
            .busy_o    (tmr_busy[g]),
            .done_o    (tmr_done[g])
        );
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            latched_q            <= 2'h0;
            therm_wait_q         <= 2'h0;
            channel_enable_bit_o <= 2'h0;
        end else if (ce_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (lat_evt[c]) begin
                    latched_q[c]            <= 1'b1;
                    channel_enable_bit_o[c] <= 1'b0;
                end else if (channel_enable_set_i[c] && !flag_live[c]) begin
                    // Enable rewrite after flag cleared reopens channel
                    latched_q[c]            <= 1'b0;
                    channel_enable_bit_o[c] <= ~pc_latch[c];
                end
                // Thermal auto-restart waits for sensor recovery
                if (th_evt[c] && !lat_evt[c])
                    therm_wait_q[c] <= 1'b1;
                else if (!cs_q[c].thermal)
                    therm_wait_q[c] <= 1'b0;
            end
        end
    end

    // Switch drive decisions; short plays no part, bootstrap undervoltage steers high and low side
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            switching_en_o     <= 2'h0;
            soft_start_o       <= 2'h0;
            highside_on_en_o   <= 2'h0;
            lowside_force_on_o <= 2'h0;
        end else if (ce_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                switching_en_o[c] <= channel_enable_bit_o[c] & ~latched_q[c]
                    & ~cs_q[c].thermal & ~therm_wait_q[c]
                    & ~cl_evt[c] & ~tmr_busy[c]
                    & ~cs_q[c].vin_uv;
                soft_start_o[c] <= therm_wait_q[c] & ~cs_q[c].thermal
                    | tmr_done[c];
                highside_on_en_o[c]   <= ~(cs_q[c].hs_limit | cs_q[c].bst_uv)
                    & ~cs_q[c].ls_limit;
                lowside_force_on_o[c] <= (cs_q[c].hs_limit | cs_q[c].bst_uv)
                    & ~cs_q[c].ls_limit;
            end
        end
    end

    // Communication watchdog
    logic [WD_BITS-1:0] wd_cnt_q;
    logic [1:0]         wd_to_cnt_q;
    logic               wd_hit;

    assign wd_hit = watchdog_enable_bit_o && wd_cnt_q[watchdog_tap_select_o];

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            watchdog_enable_bit_o <= WD_EN_RST;
            watchdog_tap_select_o <= WD_TAP_RST;
        end else if (ce_i) begin
            if (watchdog_enable_wr_i)
                watchdog_enable_bit_o <= watchdog_enable_val_i;
            if (watchdog_tap_wr_i)
                watchdog_tap_select_o <= watchdog_tap_val_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wd_cnt_q    <= '0;
            wd_to_cnt_q <= 2'h0;
            limp_home_o <= 1'b0;
            limp_set    <= 2'h0;
        end else if (ce_i) begin
            limp_set <= 2'h0;
            if (spi_frame_ok_i || !watchdog_enable_bit_o) begin
                wd_cnt_q <= '0;
                if (spi_frame_ok_i)
                    wd_to_cnt_q <= 2'h0;
            end else if (wd_hit) begin
                wd_cnt_q    <= '0;
                limp_set[0] <= 1'b1;
                if (wd_to_cnt_q != WD_LIMP_COUNT)
                    wd_to_cnt_q <= wd_to_cnt_q + 2'h1;
                if (wd_to_cnt_q == WD_LIMP_COUNT - 2'h1) begin
                    limp_home_o <= 1'b1;
                    limp_set[1] <= 1'b1;
                end
            end else begin
                wd_cnt_q <= wd_cnt_q + 25'h1;
            end
        end
    end

    // Fault pin: pulled low (oe_n low) until release with no live fault
    logic [1:0] pin_evt;
    assign pin_evt = th_evt | cl_evt;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fault_output_pin_oe_n_o <= 1'b0;
        end else if (ce_i) begin
            if (|pin_evt)
                fault_output_pin_oe_n_o <= 1'b0;
            else if (fault_pin_release_i)
                fault_output_pin_oe_n_o <= 1'b1;
        end
    end

    pin_fault_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) ce_i && |pin_evt |=> !fault_output_pin_oe_n_o)
        else $error("fault pin not driven on fault");

    release_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) ce_i && fault_pin_release_i && !(|pin_evt)
        |=> fault_output_pin_oe_n_o)
        else $error("fault pin not released");

    sequence s_clr_one;
        ce_i && clr1 && !cs_q[1].hs_limit;
    endsequence
    clear_read_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) s_clr_one |=> !fault_status_one_o[4+S1_HSLIM])
        else $error("flag not cleared on read");

    no_early_clr_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        $past(fault_status_one_o[S1_SHORT]) && !$past(clr1)
        |-> fault_status_one_o[S1_SHORT])
        else $error("flag cleared without read response");

    latch_off_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) ce_i && lat_evt[1]
        |=> !channel_enable_bit_o[1] ##1 !switching_en_o[1])
        else $error("latched channel still enabled");

    short_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) ce_i && cs_q[0].short_out
        |=> fault_status_one_o[S1_SHORT])
        else $error("short flag not set");

    wd_default_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) $rose(arst_n_i) |-> watchdog_enable_bit_o)
        else $error("watchdog not enabled after reset");

    limp_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) $rose(limp_home_o)
        |-> wd_to_cnt_q == WD_LIMP_COUNT)
        else $error("limp home without three timeouts");

    spe_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) limp_set[0] && ce_i
        |=> fault_status_three_o[S3_SPE])
        else $error("spi error flag not set");

    vin_a: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) ce_i && cs_q[0].vin_uv |=> !switching_en_o[0])
        else $error("switching on during input undervoltage");
endmodule
`default_nettype wire

// file: verification/fsv_mcu_model.sv
// Purpose: Controller model that issues SPI-derived strobes
// Assumes: Strobes launch at the falling edge, last one cycle
// Notes:   Select returns to none between transfers
`timescale 1ns/10ps
`default_nettype none
module fsv_mcu_model (
    input  wire logic           clk_sys_i,
    output var fsv_pkg::fsv_rd_sel_t rd_sel_o,
    output logic                rd_done_o,
    output logic [1:0]          enable_set_o,
    output logic                release_o,
    output logic                frame_ok_o
);
    import fsv_pkg::*;
    initial begin
        rd_sel_o = FSV_RD_NONE;
        rd_done_o = 1'b0;
        enable_set_o = 2'h0;
        release_o = 1'b0;
        frame_ok_o = 1'b0;
    end
    // Done marks the end of the response transfer
    task automatic read_status(input fsv_rd_sel_t sel);
        @(negedge clk_sys_i);
        rd_sel_o <= sel;
        rd_done_o <= 1'b1;
        frame_ok_o <= 1'b1;
        @(negedge clk_sys_i);
        rd_sel_o <= FSV_RD_NONE;
        rd_done_o <= 1'b0;
        frame_ok_o <= 1'b0;
    endtask
    // Enable write after a clearing read, also after the power-cycle read
    task automatic write_enable(input logic [1:0] ch);
        @(negedge clk_sys_i);
        enable_set_o <= ch;
        @(negedge clk_sys_i);
        enable_set_o <= 2'h0;
    endtask
    // Release write for the fault pin
    task automatic release_pin();
        @(negedge clk_sys_i);
        release_o <= 1'b1;
        @(negedge clk_sys_i);
        release_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: verification/tb_fault_supervisor.sv
// Purpose: Self-checking bench for the fault supervisor
// Assumes: Inputs change at the falling edge
// Notes:   Restart expiry (144000 cycles) is beyond the run
`timescale 1ns/10ps
`default_nettype none
module tb_fault_supervisor;
    import fsv_pkg::*;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    fsv_ch_cond_t cond [2];
    fsv_ch_cfg_t cfg [2];
    logic tw = 1'b0, auv = 1'b0, tap_wr = 1'b0;
    logic [4:0] tap_val = 5'h00;
    logic ce = 1'b1, wd_wr = 1'b0, wd_val = 1'b1;
    logic [1:0] rt_sel = 2'h0;
    fsv_rd_sel_t rd_sel;
    logic rd_done, rel, fok, wd_en, limp, oe_n, hit;
    logic [1:0] en_set, ch_en, sw_en, ss, hs_on, ls_on;
    logic [7:0] s1;
    logic [5:0] s2;
    logic [4:0] s3, tap;
    logic [31:0] seed = 32'hf2a9e9c0;
    int miscompares = 0;
    int tests_run = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    fsv_mcu_model i_mcu (.clk_sys_i(clk_sys_i), .rd_sel_o(rd_sel),
        .rd_done_o(rd_done), .enable_set_o(en_set), .release_o(rel),
        .frame_ok_o(fok));
    fsv_fault_supervisor i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .ce_i(ce), .ch_cond_i(cond), .thermal_warning_i(tw),
        .analog_supply_uv_i(auv), .ch_cfg_i(cfg),
        .restart_timer_select_i(rt_sel), .channel_enable_set_i(en_set),
        .watchdog_enable_wr_i(wd_wr), .watchdog_enable_val_i(wd_val),
        .watchdog_tap_wr_i(tap_wr), .watchdog_tap_val_i(tap_val),
        .spi_frame_ok_i(fok), .fault_pin_release_i(rel),
        .rd_done_i(rd_done), .rd_sel_i(rd_sel), .fault_status_one_o(s1),
        .fault_status_two_o(s2), .fault_status_three_o(s3),
        .channel_enable_bit_o(ch_en), .switching_en_o(sw_en),
        .soft_start_o(ss), .highside_on_en_o(hs_on),
        .lowside_force_on_o(ls_on), .watchdog_enable_bit_o(wd_en),
        .watchdog_tap_select_o(tap), .limp_home_o(limp),
        .fault_output_pin_oe_n_o(oe_n));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic read_all();
        i_mcu.read_status(FSV_RD_ONE);
        i_mcu.read_status(FSV_RD_TWO);
        i_mcu.read_status(FSV_RD_THREE);
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Whole sequence is a few hundred cycles; allow a wide margin
    initial begin
        #500_000;
        miscompares++;
        end_sim();
    end
    initial begin
        cond[0] = '0;
        cond[1] = '0;
        cfg[0] = '0;
        cfg[1] = '0;
        tick(6);
        arst_n_i = 1'b1;
        tick(1);
        chk(8'(s3), 8'h01);
        chk({s1[7:0]}, 8'h00);
        chk(8'(wd_en), 8'h01);
        chk(8'(tap), 8'h18);
        chk(8'(oe_n), 8'h00);
        i_mcu.read_status(FSV_RD_THREE);
        chk(8'(s3), 8'h00);
        i_mcu.release_pin();
        chk(8'(oe_n), 8'h01);
        i_mcu.write_enable(2'h3);
        tick(3);
        chk(8'(ch_en), 8'h03);
        $display("test power_cycle done");
        cond[0].short_out = 1'b1;
        tick(5);
        chk(s1, 8'h01);
        chk(8'(sw_en), 8'h03);
        i_mcu.read_status(FSV_RD_ONE);
        chk(s1, 8'h01);
        cond[0].short_out = 1'b0;
        tick(4);
        i_mcu.read_status(FSV_RD_TWO);
        chk(s1, 8'h01);
        i_mcu.read_status(FSV_RD_ONE);
        chk(s1, 8'h00);
        $display("test short done");
        // Random diagnostic mixes must set flags and leave pin, switching and enable alone
        repeat (4) begin
            seed = lfsr(seed);
            for (int c = 0; c < 2; c++) begin
                cond[c].bst_uv = seed[3*c];
                cond[c].comp_ov = seed[3*c+1];
                cond[c].toff_min = seed[3*c+2];
            end
            tw = seed[6];
            auv = seed[7];
            tick(5);
            chk(s1, {seed[4], 3'h0, seed[1], 3'h0});
            chk(8'(s2), {2'h0, seed[5], seed[3], 1'b0, seed[2], seed[0], 1'b0});
            chk(8'(s3), {3'h0, seed[7], seed[6], 3'h0});
            chk({oe_n, sw_en, ch_en}, 8'h1f);
            cond[0] = '0;
            cond[1] = '0;
            tw = 1'b0;
            auv = 1'b0;
            tick(4);
            read_all();
            chk(8'(s2), 8'h00);
        end
        $display("test diagnostics done");
        cfg[1].highside_limit_latch_select = 1'b1;
        cond[1].hs_limit = 1'b1;
        tick(5);
        chk(s1, 8'h20);
        chk({hs_on[1], ls_on[1]}, 8'h01);
        chk(8'(ch_en), 8'h01);
        chk(8'(oe_n), 8'h00);
        i_mcu.release_pin();
        chk(8'(oe_n), 8'h00);
        i_mcu.write_enable(2'h2);
        tick(2);
        chk(8'(ch_en), 8'h01);
        cond[1].hs_limit = 1'b0;
        tick(4);
        i_mcu.read_status(FSV_RD_ONE);
        i_mcu.write_enable(2'h2);
        tick(3);
        chk(8'(ch_en), 8'h03);
        i_mcu.release_pin();
        chk(8'(oe_n), 8'h01);
        $display("test latch done");
        cond[1].thermal = 1'b1;
        tick(5);
        chk(8'(s2), 8'h08);
        chk({sw_en, ch_en}, 8'h07);
        chk(8'(oe_n), 8'h00);
        cond[1].thermal = 1'b0;
        hit = 1'b0;
        for (int i = 0; i < 20 && !hit; i++) begin
            tick(1);
            hit = ss[1];
        end
        chk(8'(hit), 8'h01);
        tick(3);
        chk(8'(sw_en), 8'h03);
        i_mcu.read_status(FSV_RD_TWO);
        i_mcu.release_pin();
        $display("test thermal done");
        cond[0].vin_uv = 1'b1;
        tick(5);
        chk({oe_n, s2[0], s1[0], sw_en}, 8'h12);
        cond[0].vin_uv = 1'b0;
        tick(5);
        chk(8'(sw_en), 8'h03);
        rt_sel = seed[9:8];
        cond[0].ls_limit = 1'b1;
        tick(5);
        chk(s1, 8'h04);
        chk(8'(sw_en), 8'h02);
        cond[0].ls_limit = 1'b0;
        tick(200);
        chk({sw_en, ch_en}, 8'h0b);
        i_mcu.read_status(FSV_RD_ONE);
        $display("test restart done");
        tap_val = 5'h04;
        tap_wr = 1'b1;
        tick(1);
        tap_wr = 1'b0;
        chk(8'(tap), 8'h04);
        for (int i = 0; i < 300 && limp !== 1'b1; i++)
            tick(1);
        tick(1);
        chk(8'(s3), 8'h06);
        chk(8'(limp), 8'h01);
        chk(8'(ch_en), 8'h03);
        $display("test watchdog done");
        // Disabled watchdog must stop raising the error flag
        wd_val = 1'b0;
        wd_wr = 1'b1;
        tick(1);
        wd_wr = 1'b0;
        chk(8'(wd_en), 8'h00);
        i_mcu.read_status(FSV_RD_THREE);
        tick(40);
        chk(8'(s3), 8'h00);
        wd_val = 1'b1;
        wd_wr = 1'b1;
        tick(1);
        wd_wr = 1'b0;
        chk(8'(wd_en), 8'h01);
        // Clock enable low freezes flag capture
        ce = 1'b0;
        cond[0].short_out = 1'b1;
        tick(5);
        chk(s1, 8'h00);
        ce = 1'b1;
        tick(5);
        chk(s1, 8'h01);
        $display("test enable done");
        end_sim();
    end
endmodule
`default_nettype wire
